// [i2c_address_baud_buffer.sv]
// Operation
// - Master mode SCL period is four times (divider plus one) system clocks.
// - Ten-bit high byte top five bits must equal 11110, fixed in hardware.
// - Ten-bit high byte uses divider bits 2:1; bit 0 ignored.
// - Ten-bit low byte compares all eight divider bits.
// - Seven-bit mode address is divider bits 7:1; bit 0 ignored.
// - Seven-bit mode ignores the lowest mask bit.
// - Eight-bit buffer, read/write, no reset value, kept across resets.
// - Pin threshold selection is ignored while the dedicated I2C pins are used.
// - Set mask bits compare address bits; clear mask bits are excluded.
module i2c_address_baud_buffer
    import i2c_addr_pkg::*;
(
    input  wire logic        SYS_CLK,         // 20 MHz system clock
    input  wire logic        RST_N,           // Async reset, active low
    input  wire logic        PSEL,            // APB select
    input  wire logic        PENABLE,         // APB access phase
    input  wire logic        PWRITE,          // APB write
    input  wire logic [7:0]  PADDR,           // APB byte address
    input  wire logic [31:0] PWDATA,          // APB write data
    output logic      [31:0] PRDATA,          // APB read data
    output logic             PREADY,          // APB ready
    output logic             PSLVERR,         // APB error
    input  wire logic        ADDR_BYTE_VALID, // Received address byte strobe
    input  wire logic [7:0]  ADDR_BYTE,       // Received address byte
    input  wire logic        ADDR_FIRST,      // Byte is first after start
    input  wire logic        RX_VALID,        // Received data byte strobe
    input  wire logic [7:0]  RX_BYTE,         // Received data byte
    input  wire logic        DEDICATED_PINS,  // Dedicated I2C pins in use
    input  wire logic        PIN_THRESH_SEL,  // Per-pin input threshold select
    output logic             SCL_TICK,        // SCL phase enable pulse
    output logic             SCL_OUT,         // Generated SCL level
    output logic             ADDR_MATCH,      // Address match pulse
    output logic             THRESH_TTL       // Effective threshold select
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0]  mode_q, mode_d;
    logic [7:0]  mask_q, mask_d;
    logic [7:0]  addbaud_q, addbaud_d;
    logic        full_q, full_d;
    logic        hi_ok_q, hi_ok_d;
    logic [7:0]  div_q, div_d;
    logic        scl_q, scl_d;
    logic        tick_q, tick_d;
    logic        match_q, match_d;
    logic        ttl_q, ttl_d;
    logic [31:0] prdata_q, prdata_d;
    logic        err_q, err_d;
    logic [7:0]  buf_rd;
    logic        buf_we;
    logic [7:0]  buf_wd;

    typedef enum logic [2:0] {
        SL_IDLE = 3'b001,
        SL_HIGH = 3'b010,
        SL_DONE = 3'b100
    } slave_e;
    slave_e st_q, st_d;

    // Mask-aware compare over a bit range
    function automatic logic masked_eq(input logic [7:0] rx, input logic [7:0] ref_v,
                                       input logic [7:0] msk, input logic [7:0] used);
        masked_eq = (((rx ^ ref_v) & msk & used) == 8'h00);
    endfunction

    wire acc    = PSEL && PENABLE;
    wire setup  = PSEL && !PENABLE;
    wire wr     = acc && PWRITE;
    wire mapped = (PADDR == ADDR_MODE) || (PADDR == ADDR_MASK) ||
                  (PADDR == ADDR_ADDBAUD) || (PADDR == ADDR_BUFFER) ||
                  (PADDR == ADDR_STATUS);

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    always_comb begin
        mode_d    = mode_q;
        mask_d    = mask_q;
        addbaud_d = addbaud_q;
        buf_we    = 1'b0;
        buf_wd    = PWDATA[7:0];
        prdata_d  = 32'h0000_0000;
        err_d     = 1'b0;
        // Read data and error are registered at the setup edge, so they
        // stand in the access cycle together with PREADY
        if (setup) begin
            err_d = !mapped || (PWRITE && PADDR == ADDR_STATUS);
        end
        if (setup && !PWRITE) begin
            unique case (PADDR)
                ADDR_MODE:    prdata_d = {30'h0, mode_q};
                ADDR_MASK:    prdata_d = {24'h0, mask_q};
                ADDR_ADDBAUD: prdata_d = {24'h0, addbaud_q};
                ADDR_BUFFER:  prdata_d = {24'h0, buf_rd};
                ADDR_STATUS:  prdata_d = {29'h0, hi_ok_q, match_q, full_q};
                default:      prdata_d = 32'h0000_0000;
            endcase
        end
        // Writes land at the access edge, where PREADY is sampled high
        if (wr) begin
            unique case (PADDR)
                ADDR_MODE:    mode_d    = PWDATA[1:0];
                ADDR_MASK:    mask_d    = PWDATA[7:0];
                ADDR_ADDBAUD: addbaud_d = PWDATA[7:0];
                ADDR_BUFFER:  buf_we    = 1'b1;
                default:      ;
            endcase
        end
        // Hardware receive loads the buffer unless software writes it this cycle
        if (RX_VALID && !buf_we) begin
            buf_we = 1'b1;
            buf_wd = RX_BYTE;
        end
    end

    // Full flag: hardware set wins over the clear from a buffer read
    always_comb begin
        full_d = full_q;
        if (acc && !PWRITE && PADDR == ADDR_BUFFER) begin
            full_d = 1'b0;
        end
        if (RX_VALID) begin
            full_d = 1'b1;
        end
    end

    serial_buffer u_buf (
        .clk     (SYS_CLK),
        .wr_en   (buf_we),
        .wr_data (buf_wd),
        .rd_data (buf_rd)
    );

    // ------------------------------------------------------------
    // Baud divider
    // ------------------------------------------------------------
    // Each SCL phase lasts (divider + 1) clocks; four phases make a period,
    // so SCL toggles every second tick.
    logic [1:0] phase_q, phase_d;
    always_comb begin
        div_d   = div_q;
        phase_d = phase_q;
        scl_d   = scl_q;
        tick_d  = 1'b0;
        if (mode_q != MODE_MASTER) begin
            div_d   = 8'h00;
            phase_d = 2'h0;
            scl_d   = 1'b1;
        end else if (div_q == addbaud_q) begin
            div_d   = 8'h00;
            tick_d  = 1'b1;
            phase_d = phase_q + 2'h1;
            if (phase_q[0]) begin
                scl_d = !scl_q;
            end
        end else begin
            div_d = div_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Slave address matching
    // ------------------------------------------------------------
    logic m7, m10hi, m10lo;
    always_comb begin
        // Bit 0 of both mask and address excluded in 7-bit mode
        m7 = masked_eq(ADDR_BYTE, addbaud_q, mask_q, 8'hfe);
        // Header pattern fixed; register bits 7:3 and 0 unused
        m10hi = (ADDR_BYTE[7:3] == TEN_BIT_HDR) &&
                masked_eq(ADDR_BYTE, addbaud_q, mask_q, 8'h06);
        m10lo = masked_eq(ADDR_BYTE, addbaud_q, mask_q, 8'hff);
        st_d    = st_q;
        hi_ok_d = hi_ok_q;
        match_d = 1'b0;
        if (ADDR_BYTE_VALID) begin
            unique case (mode_q)
                MODE_SLAVE7: begin
                    match_d = ADDR_FIRST && m7;
                    st_d    = SL_IDLE;
                end
                MODE_SLAVE10: begin
                    if (ADDR_FIRST) begin
                        st_d    = m10hi ? SL_HIGH : SL_IDLE;
                        hi_ok_d = m10hi;
                    end else if (st_q == SL_HIGH) begin
                        match_d = m10lo;
                        st_d    = m10lo ? SL_DONE : SL_IDLE;
                    end
                end
                default: st_d = SL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Threshold and pin inputs are synchronised before use
    logic [1:0] ded_sync_q, thr_sync_q;
    always_comb begin
        ttl_d = ded_sync_q[1] ? 1'b0 : thr_sync_q[1];
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q     <= MODE_RST;
            mask_q     <= MASK_RST;
            addbaud_q  <= ADDBAUD_RST;
            full_q     <= 1'b0;
            hi_ok_q    <= 1'b0;
            div_q      <= 8'h00;
            phase_q    <= 2'h0;
            scl_q      <= 1'b1;
            tick_q     <= 1'b0;
            match_q    <= 1'b0;
            ttl_q      <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            err_q      <= 1'b0;
            st_q       <= SL_IDLE;
            ded_sync_q <= 2'h0;
            thr_sync_q <= 2'h0;
        end else begin
            mode_q     <= mode_d;
            mask_q     <= mask_d;
            addbaud_q  <= addbaud_d;
            full_q     <= full_d;
            hi_ok_q    <= hi_ok_d;
            div_q      <= div_d;
            phase_q    <= phase_d;
            scl_q      <= scl_d;
            tick_q     <= tick_d;
            match_q    <= match_d;
            ttl_q      <= ttl_d;
            prdata_q   <= prdata_d;
            err_q      <= err_d;
            st_q       <= st_d;
            ded_sync_q <= {ded_sync_q[0], DEDICATED_PINS};
            thr_sync_q <= {thr_sync_q[0], PIN_THRESH_SEL};
        end
    end

    // PREADY is registered from the setup cycle: the access phase has no wait state
    logic ready_q;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= PSEL && !PENABLE;
        end
    end

    assign PRDATA     = prdata_q;
    assign PREADY     = ready_q;
    assign PSLVERR    = err_q;
    assign SCL_TICK   = tick_q;
    assign SCL_OUT    = scl_q;
    assign ADDR_MATCH = match_q;
    assign THRESH_TTL = ttl_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [9:0] gap_q;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gap_q <= 10'h000;
        end else begin
            gap_q <= tick_q ? 10'h000 : gap_q + 10'h001;
        end
    end

    // Divider seen at the last tick, and whether it and master mode have held since;
    // a period straddling a divider write or mode change is not checked
    logic [7:0] tick_div_q;
    logic       steady_q;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_div_q <= 8'h00;
            steady_q   <= 1'b0;
        end else begin
            if (tick_q) begin
                tick_div_q <= addbaud_q;
            end
            if (mode_q != MODE_MASTER) begin
                steady_q <= 1'b0;
            end else if (tick_q) begin
                steady_q <= 1'b1;
            end else if (addbaud_q != tick_div_q) begin
                steady_q <= 1'b0;
            end
        end
    end

    tick_spacing_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ($changed(scl_q) && $past(mode_q) == MODE_MASTER) |-> (tick_q && $past(phase_q[0])))
        else $error("divider tick spacing wrong");

    tick_period_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (tick_q && steady_q) |-> (gap_q == {2'h0, tick_div_q}))
        else $error("tick period not divider plus one");

    hdr_fixed_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ADDR_BYTE_VALID && ADDR_FIRST && mode_q == MODE_SLAVE10 &&
         ADDR_BYTE[7:3] != TEN_BIT_HDR) |=> (st_q == SL_IDLE && !hi_ok_q))
        else $error("ten-bit header accepted without fixed pattern");

    seven_match_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ADDR_BYTE_VALID && ADDR_FIRST && mode_q == MODE_SLAVE7)
        |=> (match_q == ((($past(ADDR_BYTE) ^ $past(addbaud_q)) & $past(mask_q) &
                          8'hfe) == 8'h00)))
        else $error("seven-bit match wrong");

    seven_bit0_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        m7 == (((ADDR_BYTE[7:1] ^ addbaud_q[7:1]) & mask_q[7:1]) == 7'h00))
        else $error("seven-bit match depends on bit zero");

    ten_order_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        match_q && $past(mode_q) == MODE_SLAVE10 |-> $past(st_q) == SL_HIGH)
        else $error("ten-bit match without high byte");

    full_set_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (RX_VALID && !(wr && PADDR == ADDR_BUFFER)) |=> full_q && (buf_rd == $past(RX_BYTE)))
        else $error("receive byte not held in buffer");

    thresh_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ded_sync_q[1] |=> !THRESH_TTL)
        else $error("threshold select not ignored on dedicated pins");
endmodule // i2c_address_baud_buffer

// [i2c_addr_pkg.sv]
package i2c_addr_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE     = 8'h00;
    localparam logic [7:0] ADDR_MASK     = 8'h04;
    localparam logic [7:0] ADDR_ADDBAUD  = 8'h08;
    localparam logic [7:0] ADDR_BUFFER   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    // ------------------------------------------------------------
    // Mode field values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_MASTER   = 2'h0;
    localparam logic [1:0] MODE_SLAVE7   = 2'h1;
    localparam logic [1:0] MODE_SLAVE10  = 2'h2;
    localparam logic [1:0] MODE_OFF      = 2'h3;
    // ------------------------------------------------------------
    // Reset values and fixed patterns
    // ------------------------------------------------------------
    localparam logic [7:0] ADDBAUD_RST   = 8'h00;
    localparam logic [7:0] MASK_RST      = 8'hff;
    localparam logic [1:0] MODE_RST      = MODE_OFF;
    localparam logic [4:0] TEN_BIT_HDR   = 5'h1e;
    localparam int         SCL_PHASES    = 4;
    localparam int         STAT_BF_BIT   = 0;
    localparam int         STAT_MATCH_BIT = 1;
    localparam int         STAT_HIGH_BIT = 2;
endpackage

// [serial_buffer.sv]
module serial_buffer (
    input  wire logic       clk,      // System clock
    input  wire logic       wr_en,    // Load strobe
    input  wire logic [7:0] wr_data,  // Byte to store
    output logic      [7:0] rd_data   // Stored byte
);
    // ------------------------------------------------------------
    // Storage with no reset: kept across every reset
    // ------------------------------------------------------------
    logic [7:0] buf_q;
    logic [7:0] buf_d;

    always_comb begin
        buf_d = wr_en ? wr_data : buf_q;
    end

    always_ff @(posedge clk) begin
        buf_q <= buf_d;
    end

    assign rd_data = buf_q;
endmodule // serial_buffer

// [i2c_bus_master_model.sv]
module i2c_bus_master_model (
    input  wire logic       clk,        // System clock
    output logic            addr_valid, // Address byte strobe
    output logic      [7:0] addr_byte,  // Address byte
    output logic            addr_first, // First byte after start
    output logic            rx_valid,   // Data byte strobe
    output logic      [7:0] rx_byte     // Data byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Far-side byte source
    // ------------------------------------------------------------
    // Idle data lines carry the inverse of the last byte, so a stale
    // byte is never mistaken for a fresh one.
    initial begin
        addr_valid = 1'b0;
        addr_byte  = 8'h5a;
        addr_first = 1'b0;
        rx_valid   = 1'b0;
        rx_byte    = 8'ha5;
    end

    task automatic send_addr(input logic [7:0] b, input logic f);
        @(posedge clk);
        addr_valid <= 1'b1;
        addr_byte  <= b;
        addr_first <= f;
        @(posedge clk);
        addr_valid <= 1'b0;
        addr_byte  <= ~b;
        addr_first <= ~f;
    endtask

    task automatic send_data(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~b;
    endtask
endmodule // i2c_bus_master_model

// [i2c_address_baud_buffer_test.sv]
module i2c_address_baud_buffer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_addr_pkg::*;
    logic        SYS_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic        DEDICATED_PINS = 1'b0, PIN_THRESH_SEL = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic        PREADY, PSLVERR, SCL_TICK, SCL_OUT, ADDR_MATCH, THRESH_TTL, er;
    logic        ADDR_BYTE_VALID, ADDR_FIRST, RX_VALID;
    logic [7:0]  ADDR_BYTE, RX_BYTE;
    int          error_cnt = 0, check_count = 0, g, tk;
    typedef struct {logic [1:0] m; logic [7:0] k, a, b1, b2; logic two, exp;} row_s;
    row_s rows[11] = '{
        '{MODE_SLAVE7, 8'hff, 8'ha4, 8'ha5, 8'h00, 1'b0, 1'b1},
        '{MODE_SLAVE7, 8'hff, 8'ha4, 8'ha6, 8'h00, 1'b0, 1'b0},
        '{MODE_SLAVE7, 8'hfe, 8'ha4, 8'ha5, 8'h00, 1'b0, 1'b1},
        '{MODE_SLAVE7, 8'hf0, 8'ha4, 8'hab, 8'h00, 1'b0, 1'b1},
        '{MODE_SLAVE7, 8'hff, 8'ha4, 8'hab, 8'h00, 1'b0, 1'b0},
        '{MODE_SLAVE10, 8'hff, 8'h06, 8'hf6, 8'h06, 1'b1, 1'b1},
        '{MODE_SLAVE10, 8'hff, 8'h06, 8'h06, 8'h06, 1'b1, 1'b0},
        '{MODE_SLAVE10, 8'hff, 8'h06, 8'hf4, 8'h06, 1'b1, 1'b0},
        '{MODE_SLAVE10, 8'hff, 8'h06, 8'hf6, 8'h07, 1'b1, 1'b0},
        '{MODE_SLAVE10, 8'hfe, 8'h06, 8'hf6, 8'h07, 1'b1, 1'b1},
        '{MODE_MASTER, 8'hff, 8'ha4, 8'ha5, 8'h00, 1'b0, 1'b0}};

    i2c_address_baud_buffer uut (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .ADDR_BYTE_VALID(ADDR_BYTE_VALID),
        .ADDR_BYTE(ADDR_BYTE), .ADDR_FIRST(ADDR_FIRST), .RX_VALID(RX_VALID),
        .RX_BYTE(RX_BYTE), .DEDICATED_PINS(DEDICATED_PINS),
        .PIN_THRESH_SEL(PIN_THRESH_SEL), .SCL_TICK(SCL_TICK), .SCL_OUT(SCL_OUT),
        .ADDR_MATCH(ADDR_MATCH), .THRESH_TTL(THRESH_TTL));
    i2c_bus_master_model p (
        .clk(SYS_CLK), .addr_valid(ADDR_BYTE_VALID), .addr_byte(ADDR_BYTE),
        .addr_first(ADDR_FIRST), .rx_valid(RX_VALID), .rx_byte(RX_BYTE));

    initial begin
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        check_count++;
        if (v !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, v);
            error_cnt++;
        end
    endtask

    // Request held until PREADY is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1);
        chk("pready_wait", 32'h1, n);
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic scl_gap(output int gap, output int ticks);
        int r1;
        logic prv;
        r1 = -1;
        gap = 0;
        ticks = 0;
        prv = 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge SYS_CLK);
            #1;
            if (r1 >= 0 && SCL_TICK === 1'b1) begin
                ticks++;
            end
            if (SCL_OUT === 1'b1 && prv === 1'b0) begin
                if (r1 >= 0) begin
                    gap = n - r1;
                    break;
                end
                r1 = n;
            end
            prv = SCL_OUT;
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run is a few hundred cycles; twenty thousand means a hang
    initial begin
        #1000000;
        error_cnt++;
        test_done;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        apb(1'b0, ADDR_MODE, 32'h0);
        chk("mode_rst", {30'h0, MODE_RST}, rd);
        apb(1'b0, ADDR_MASK, 32'h0);
        chk("mask_rst", {24'h0, MASK_RST}, rd);
        apb(1'b0, ADDR_ADDBAUD, 32'h0);
        chk("addbaud_rst", {24'h0, ADDBAUD_RST}, rd);
        foreach (rows[i]) begin
            apb(1'b1, ADDR_MODE, {30'h0, rows[i].m});
            apb(1'b1, ADDR_MASK, {24'h0, rows[i].k});
            apb(1'b1, ADDR_ADDBAUD, {24'h0, rows[i].a});
            p.send_addr(rows[i].b1, 1'b1);
            #1;
            if (rows[i].two) begin
                chk("match_high_only", 32'h0, {31'h0, ADDR_MATCH});
                p.send_addr(rows[i].b2, 1'b0);
                #1;
            end
            chk("match", {31'h0, rows[i].exp}, {31'h0, ADDR_MATCH});
        end
        for (int d = 0; d < 3; d += 2) begin
            apb(1'b1, ADDR_MODE, {30'h0, MODE_OFF});
            apb(1'b1, ADDR_ADDBAUD, d);
            apb(1'b1, ADDR_MODE, {30'h0, MODE_MASTER});
            scl_gap(g, tk);
            chk("scl_period", 4 * (d + 1), g);
            chk("scl_ticks", 32'h4, tk);
        end
        @(posedge SYS_CLK);
        PIN_THRESH_SEL <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        #1;
        chk("thresh_free", 32'h1, {31'h0, THRESH_TTL});
        @(posedge SYS_CLK);
        DEDICATED_PINS <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        #1;
        chk("thresh_dedicated", 32'h0, {31'h0, THRESH_TTL});
        apb(1'b1, ADDR_BUFFER, 32'h1a5);
        apb(1'b0, ADDR_BUFFER, 32'h0);
        chk("buffer_rw", 32'ha5, rd);
        p.send_data(8'h3c);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("buffer_full", 32'h1, {31'h0, rd[STAT_BF_BIT]});
        apb(1'b1, ADDR_STATUS, 32'hff);
        chk("status_ro_err", 32'h1, {31'h0, er});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        apb(1'b0, ADDR_BUFFER, 32'h0);
        chk("buffer_kept", 32'h3c, rd);
        apb(1'b0, ADDR_MODE, 32'h0);
        chk("mode_rst2", {30'h0, MODE_RST}, rd);
        test_done;
    end
endmodule // i2c_address_baud_buffer_test
